// ===== verilog/scsi_stat_pkg.sv
// constants and carrier types for the scsi status and table-indirect base block
package scsi_stat_pkg;
  // ==================================================
  // register byte offsets
  localparam logic [7:0] OFF_STATUS_ONE = 8'h0e;
  localparam logic [7:0] OFF_STATUS_TWO = 8'h0f;
  localparam logic [7:0] OFF_BASE_B0 = 8'h10;
  localparam logic [7:0] OFF_BASE_B1 = 8'h11;
  localparam logic [7:0] OFF_BASE_B2 = 8'h12;
  localparam logic [7:0] OFF_BASE_B3 = 8'h13;
  // ==================================================
  // field positions in scsi_status_one
  localparam int POS_FIFO_LOW = 4;
  localparam int POS_LOW_PARITY = 3;
  localparam int POS_MSG = 2;
  localparam int POS_CD = 1;
  localparam int POS_IO = 0;
  // ==================================================
  // field positions in scsi_status_two
  localparam int POS_IN_HIGH_FULL = 7;
  localparam int POS_BUF_HIGH_FULL = 6;
  localparam int POS_OUT_HIGH_FULL = 5;
  localparam int POS_FIFO_TOP = 4;
  localparam int POS_HIGH_PARITY = 3;
  localparam int POS_CABLE = 2;
  localparam int POS_LAST_DISC = 1;
  localparam int POS_LIVE_PARITY = 0;
  // ==================================================
  // sizes and reset values
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int WORD_W = 16;
  localparam logic [4:0] FIFO_FULL_COUNT = 5'h10;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic LAST_DISC_RESET = 1'b1;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // ==================================================
  // carriers
  typedef struct packed {
    logic msg;
    logic cd;
    logic io;
  } phase_type;

  typedef struct packed {
    logic [15:0] data;
    logic wide;
  } word_type;
endpackage

// ===== verilog/pair_buffer.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
module pair_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] slot [2];
  logic [1:0] fill;
  logic rd_ptr;
  logic wr_ptr;
  logic push;
  logic pop;

  assign in_ready_o = (fill != 2'd2);
  assign out_valid_o = (fill != 2'd0);
  assign out_data_o = slot[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fill <= 2'd0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        fill <= fill + 2'd1;
      end else if (pop && !push) begin
        fill <= fill - 2'd1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      slot[wr_ptr] <= in_data_i;
    end
  end
endmodule

// ===== verilog/scsi_status_regs.sv
// scsi status registers, data latches, sync fifo and table-indirect base
// What this block does
// R01 - five-bit fifo count split over both registers
// R02 - fifo count read live, unlatched
// R03 - low parity captured with low latch byte
// R04 - phase lines captured on request assert edge
// R05 - captured phase bit one when line active
// R06 - input latch high byte full flag
// R07 - holding buffer high byte full flag
// R08 - output latch high byte full flag
// R09 - sync sends via buffer, async direct
// R10 - high parity captured with high latch byte
// R11 - cable sense bit: zero differential, one single-ended
// R12 - last disconnect set while not connected
// R13 - cleared by block move while connected
// R14 - software: both set means earlier disconnect
// R15 - live high parity line shown unlatched
// R16 - 32-bit read/write table-indirect base
// R17 - base kept from host writes during memory-to-memory moves; script loads still apply
// R18 - script move or host may load base
// R19 - software loads base before use
// R20 - connected set on selection or response
// R21 - writes to status registers ignored
`timescale 1ns/1ps
module scsi_status_regs (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // script engine
  input wire logic mem_move_active_i,
  input wire logic script_base_wr_i,
  input wire logic [31:0] script_base_data_i,
  output logic [31:0] table_indirect_base_o,
  input wire logic block_move_exec_i,
  input wire logic selection_done_i,
  input wire logic select_response_i,
  input wire logic bus_released_i,
  output logic connected_flag_o,
  // bus status lines, active low except the cable sense, which is one for single-ended
  input wire logic request_pin_n_i,
  input wire logic msg_n_i,
  input wire logic cd_n_i,
  input wire logic io_n_i,
  input wire logic parity_low_n_i,
  input wire logic parity_high_n_i,
  input wire logic single_ended_cable_i,
  // asynchronous receive into the input latch
  input wire logic async_in_strobe_i,
  input wire scsi_stat_pkg::word_type async_in_word_i,
  input wire logic in_latch_take_i,
  // synchronous receive into the fifo
  input wire logic sync_in_valid_i,
  output logic sync_in_ready_o,
  input wire logic [15:0] sync_in_data_i,
  output logic fifo_out_valid_o,
  input wire logic fifo_out_ready_i,
  output logic [15:0] fifo_out_data_o,
  // send path
  input wire logic sync_mode_i,
  input wire logic out_latch_load_i,
  input wire scsi_stat_pkg::word_type out_latch_word_i,
  output logic out_latch_ready_o,
  output logic bus_out_valid_o,
  output scsi_stat_pkg::word_type bus_out_word_o,
  input wire logic bus_out_take_i
);
  import scsi_stat_pkg::*;

  // ==================================================
  // declarations
  logic [15:0] fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] fifo_wr;
  logic [FIFO_AW-1:0] fifo_rd;
  logic [4:0] fifo_count;
  logic fifo_push;
  logic fifo_pop;
  logic buf_in_ready;
  logic request_prev;
  phase_type phase_latched;
  logic low_parity;
  logic high_parity;
  logic in_low_full;
  logic in_high_full;
  word_type in_latch;
  word_type out_latch;
  logic out_low_full;
  logic out_high_full;
  word_type hold_buf;
  logic hold_low_full;
  logic hold_high_full;
  logic out_to_hold;
  logic out_to_bus;
  logic hold_to_bus;
  logic connected;
  logic last_disc;
  logic [31:0] base;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [7:0] next_rdata;

  // ==================================================
  // synchronous receive fifo
  assign sync_in_ready_o = (fifo_count != FIFO_FULL_COUNT);
  assign fifo_push = sync_in_valid_i & sync_in_ready_o;
  assign fifo_pop = (fifo_count != 5'h00) & buf_in_ready;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_wr <= '0;
      fifo_rd <= '0;
      fifo_count <= 5'h00;
    end else begin
      if (fifo_push) begin
        fifo_wr <= fifo_wr + 4'h1;
      end
      if (fifo_pop) begin
        fifo_rd <= fifo_rd + 4'h1;
      end
      if (fifo_push && !fifo_pop) begin
        fifo_count <= fifo_count + 5'h01;
      end else if (fifo_pop && !fifo_push) begin
        fifo_count <= fifo_count - 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (fifo_push) begin
      fifo_mem[fifo_wr] <= sync_in_data_i;
    end
  end

  pair_buffer #(
    .WIDTH(WORD_W)
  ) u_fifo_out (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_count != 5'h00),
    .in_ready_o(buf_in_ready),
    .in_data_i(fifo_mem[fifo_rd]),
    .out_valid_o(fifo_out_valid_o),
    .out_ready_i(fifo_out_ready_i),
    .out_data_o(fifo_out_data_o)
  );

  // ==================================================
  // phase capture on request edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      request_prev <= 1'b1;
      phase_latched <= '0;
    end else begin
      request_prev <= request_pin_n_i;
      if (request_prev && !request_pin_n_i) begin
        phase_latched <= '{msg: ~msg_n_i, cd: ~cd_n_i, io: ~io_n_i}; // R04 R05
      end
    end
  end

  // ==================================================
  // asynchronous input latch
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      in_latch <= '0;
      in_low_full <= 1'b0;
      in_high_full <= 1'b0;
      low_parity <= 1'b0;
      high_parity <= 1'b0;
    end else begin
      if (in_latch_take_i) begin
        in_low_full <= 1'b0;
        in_high_full <= 1'b0;
      end
      if (async_in_strobe_i) begin
        in_latch <= async_in_word_i;
        in_low_full <= 1'b1;
        low_parity <= ~parity_low_n_i; // R03
        if (async_in_word_i.wide) begin
          in_high_full <= 1'b1; // R06
          high_parity <= ~parity_high_n_i; // R10
        end
      end
    end
  end

  // ==================================================
  // output latch and hidden holding buffer
  assign out_to_hold = sync_mode_i & out_low_full & ~hold_low_full; // R09
  assign out_to_bus = ~sync_mode_i & out_low_full & bus_out_take_i; // R09
  assign hold_to_bus = sync_mode_i & hold_low_full & bus_out_take_i;
  assign out_latch_ready_o = ~out_low_full;
  assign bus_out_valid_o = sync_mode_i ? hold_low_full : out_low_full;
  assign bus_out_word_o = sync_mode_i ? hold_buf : out_latch;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      out_latch <= '0;
      out_low_full <= 1'b0;
      out_high_full <= 1'b0;
    end else begin
      if (out_to_hold || out_to_bus) begin
        out_low_full <= 1'b0;
        out_high_full <= 1'b0;
      end
      if (out_latch_load_i && !out_low_full) begin
        out_latch <= out_latch_word_i;
        out_low_full <= 1'b1;
        out_high_full <= out_latch_word_i.wide; // R08
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hold_buf <= '0;
      hold_low_full <= 1'b0;
      hold_high_full <= 1'b0;
    end else begin
      if (hold_to_bus) begin
        hold_low_full <= 1'b0;
        hold_high_full <= 1'b0;
      end
      if (out_to_hold) begin
        hold_buf <= out_latch;
        hold_low_full <= 1'b1;
        hold_high_full <= out_latch.wide; // R07
      end
    end
  end

  // ==================================================
  // connection state and last disconnect
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      connected <= 1'b0;
    end else if (selection_done_i || select_response_i) begin
      connected <= 1'b1; // R20
    end else if (bus_released_i) begin
      connected <= 1'b0;
    end
  end

  // both set at once tells software of an earlier disconnect R14
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      last_disc <= LAST_DISC_RESET;
    end else if (!connected) begin
      last_disc <= 1'b1; // R12
    end else if (block_move_exec_i) begin
      last_disc <= 1'b0; // R13
    end
  end

  assign connected_flag_o = connected;

  // ==================================================
  // table-indirect base
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      base <= BASE_RESET; // R19
    end else if (script_base_wr_i) begin
      base <= script_base_data_i; // R18
    end else if (reg_wr_i && !mem_move_active_i) begin // R17
      unique case (reg_addr_i)
        OFF_BASE_B0: base[7:0] <= reg_wdata_i; // R16
        OFF_BASE_B1: base[15:8] <= reg_wdata_i;
        OFF_BASE_B2: base[23:16] <= reg_wdata_i;
        OFF_BASE_B3: base[31:24] <= reg_wdata_i;
        default: base <= base; // R21
      endcase
    end
  end

  assign table_indirect_base_o = base;

  // ==================================================
  // read path
  always_comb begin
    status_one = 8'h00;
    status_one[POS_FIFO_LOW +: 4] = fifo_count[3:0]; // R01 R02
    status_one[POS_LOW_PARITY] = low_parity;
    status_one[POS_MSG] = phase_latched.msg;
    status_one[POS_CD] = phase_latched.cd;
    status_one[POS_IO] = phase_latched.io;
    status_two = 8'h00;
    status_two[POS_IN_HIGH_FULL] = in_high_full;
    status_two[POS_BUF_HIGH_FULL] = hold_high_full;
    status_two[POS_OUT_HIGH_FULL] = out_high_full;
    status_two[POS_FIFO_TOP] = fifo_count[4]; // R01
    status_two[POS_HIGH_PARITY] = high_parity;
    status_two[POS_CABLE] = single_ended_cable_i; // R11
    status_two[POS_LAST_DISC] = last_disc;
    status_two[POS_LIVE_PARITY] = ~parity_high_n_i; // R15
  end

  always_comb begin
    unique case (reg_addr_i)
      OFF_STATUS_ONE: next_rdata = status_one;
      OFF_STATUS_TWO: next_rdata = status_two;
      OFF_BASE_B0: next_rdata = base[7:0];
      OFF_BASE_B1: next_rdata = base[15:8];
      OFF_BASE_B2: next_rdata = base[23:16];
      OFF_BASE_B3: next_rdata = base[31:24];
      default: next_rdata = RDATA_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= RDATA_RESET;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end
endmodule

// ===== verif/scsi_status_regs_chk.sv
// checker bound to the scsi status block
`timescale 1ns/1ps
module scsi_status_regs_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic mem_move_active_i,
  input wire logic script_base_wr_i,
  input wire logic [31:0] script_base_data_i,
  input wire logic [31:0] table_indirect_base_o,
  input wire logic selection_done_i,
  input wire logic connected_flag_o,
  input wire logic request_pin_n_i,
  input wire logic msg_n_i,
  input wire logic cd_n_i,
  input wire logic io_n_i,
  input wire logic parity_high_n_i,
  input wire logic single_ended_cable_i,
  input wire logic sync_mode_i,
  input wire logic out_latch_load_i,
  input wire logic out_latch_ready_o,
  input wire logic bus_out_valid_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  logic rd_two;
  assign rd_two = reg_rd_i && reg_addr_i == 8'h0f;
  // ==================================================
  // port relations
  AST_LIVE_BITS: assert property (rd_two |=> reg_rdata_o[2] == $past(single_ended_cable_i)
    && reg_rdata_o[0] == !$past(parity_high_n_i)) else $error("live status bits wrong");
  AST_PHASE_CAPTURE: assert property ($fell(request_pin_n_i) ##1 rd_two == 1'h0
    && reg_rd_i && reg_addr_i == 8'h0e
    |=> reg_rdata_o[2:0] == ~$past({msg_n_i, cd_n_i, io_n_i}, 2)) else $error("phase bits wrong");
  AST_LAST_DISC: assert property (!connected_flag_o ##1 rd_two |=> reg_rdata_o[1])
    else $error("last disconnect not set");
  AST_CONNECT: assert property (selection_done_i |=> connected_flag_o)
    else $error("connected not set");
  AST_SCRIPT_BASE: assert property (script_base_wr_i
    |=> table_indirect_base_o == $past(script_base_data_i)) else $error("script load wrong");
  AST_MOVE_HOLD: assert property (mem_move_active_i && !script_base_wr_i
    |=> $stable(table_indirect_base_o)) else $error("base changed in move");
  AST_HOST_BASE: assert property (reg_wr_i && reg_addr_i == 8'h13 && !mem_move_active_i
    && !script_base_wr_i |=> table_indirect_base_o[31:24] == $past(reg_wdata_i))
    else $error("host base write wrong");
  AST_STATUS_WRITE: assert property (reg_wr_i && !reg_rd_i && reg_addr_i[7:1] == 7'h07
    && !script_base_wr_i
    |=> $stable(table_indirect_base_o) && $stable(reg_rdata_o))
    else $error("status write acted");
  AST_ASYNC_SEND: assert property (!sync_mode_i && out_latch_load_i && out_latch_ready_o
    |=> bus_out_valid_o) else $error("async word not direct");
  AST_SYNC_SEND: assert property (sync_mode_i && out_latch_load_i && out_latch_ready_o
    && !bus_out_valid_o |=> !out_latch_ready_o ##1 bus_out_valid_o) else $error("sync path wrong");
endmodule
bind scsi_status_regs scsi_status_regs_chk i_scsi_status_regs_chk (.*);

// ===== verif/scsi_bus_model.sv
// far-side bus device: phase requests, word taker, fifo drain
`timescale 1ns/1ps
module scsi_bus_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire scsi_stat_pkg::phase_type phase_i,
  input wire logic req_go_i,
  input wire logic stall_i,
  input wire logic bus_out_valid_i,
  output logic bus_out_take_o,
  output logic fifo_out_ready_o,
  output logic request_pin_n_o,
  output logic msg_n_o,
  output logic cd_n_o,
  output logic io_n_o
);
  import scsi_stat_pkg::*;
  logic [1:0] step;
  phase_type held;
  // lines set one cycle before request, released to pull-up after
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      step <= 2'h0;
      held <= '0;
    end else begin
      step <= req_go_i ? 2'h1 : (step == 2'h1 ? 2'h2 : 2'h0);
      held <= req_go_i ? phase_i : held;
    end
  end
  assign request_pin_n_o = step != 2'h2;
  assign {msg_n_o, cd_n_o, io_n_o} = (step != 2'h0) ? ~held : 3'h7;
  assign bus_out_take_o = bus_out_valid_i && !stall_i;
  assign fifo_out_ready_o = !stall_i;
endmodule

// ===== verif/scsi_status_regs_tb_top.sv
// self-checking bench for the scsi status block
`timescale 1ns/1ps
module scsi_status_regs_tb_top;
  import scsi_stat_pkg::*;
  logic clk_sys_i = 1'h0;
  logic rst_i;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic reg_rd_i = 1'h0, reg_wr_i = 1'h0, mem_move_active_i = 1'h0, script_base_wr_i = 1'h0;
  logic [31:0] script_base_data_i = 32'h0000_0000, table_indirect_base_o, v;
  logic block_move_exec_i = 1'h0, selection_done_i = 1'h0, select_response_i = 1'h0;
  logic bus_released_i = 1'h0, connected_flag_o, request_pin_n_i, msg_n_i, cd_n_i, io_n_i;
  logic parity_low_n_i = 1'h1, parity_high_n_i = 1'h1, single_ended_cable_i = 1'h0;
  logic async_in_strobe_i = 1'h0, in_latch_take_i = 1'h0, sync_in_valid_i = 1'h0;
  logic sync_in_ready_o, fifo_out_valid_o, fifo_out_ready_i, sync_mode_i = 1'h0;
  logic [15:0] sync_in_data_i = 16'h0000, fifo_out_data_o, fq[$], rdq[$];
  logic out_latch_load_i = 1'h0, out_latch_ready_o, bus_out_valid_o, bus_out_take_i;
  logic req_go = 1'h0, stall = 1'h1, rd_seen = 1'h0;
  logic [1:0] p;
  word_type async_in_word_i = '0, out_latch_word_i = '0, bus_out_word_o, bq[$];
  phase_type phase = '0;
  int num_errors = 0, checks_done = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  scsi_status_regs i_scsi_status_regs (.*);
  scsi_bus_model i_scsi_bus_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .phase_i(phase),
    .req_go_i(req_go), .stall_i(stall), .bus_out_valid_i(bus_out_valid_o),
    .bus_out_take_o(bus_out_take_i), .fifo_out_ready_o(fifo_out_ready_i),
    .request_pin_n_o(request_pin_n_i), .msg_n_o(msg_n_i), .cd_n_o(cd_n_i), .io_n_o(io_n_i));
  // ==================================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    single_ended_cable_i = 1'($urandom);
    if (a == 8'h0f) begin
      e = {e[7:3], single_ended_cable_i, e[1], !parity_high_n_i};
      m = m | 8'h05;
    end
    reg_addr_i = a;
    reg_rd_i = 1'h1;
    rdq.push_back({m, e & m});
    @(negedge clk_sys_i);
    reg_rd_i = 1'h0;
    @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'h0;
    @(negedge clk_sys_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge clk_sys_i);
    s = 1'h0;
    @(negedge clk_sys_i);
  endtask
  task automatic load(input word_type w);
    out_latch_word_i = w;
    bq.push_back(w);
    pulse(out_latch_load_i);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==================================================
  // output monitor
  always @(posedge clk_sys_i) begin
    if (rd_seen) begin
      check("read data", reg_rdata_o & rdq[0][15:8], rdq[0][7:0]);
      void'(rdq.pop_front());
    end
    if (fifo_out_valid_o === 1'h1 && fifo_out_ready_i) begin
      check("fifo word", fifo_out_data_o, fq[0]);
      void'(fq.pop_front());
    end
    if (bus_out_valid_o === 1'h1 && bus_out_take_i) begin
      check("bus word", bus_out_word_o, bq[0]);
      void'(bq.pop_front());
    end
    rd_seen <= reg_rd_i;
  end
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    num_errors++;
    complete_run();
  end
  // ==================================================
  // scenarios
  initial begin
    void'($urandom(32'h0000_c685));
    rst_i = 1'h1;
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'h0;
    rd(8'h0e, 8'h00, 8'hf0);
    rd(8'h0f, 8'h02, 8'hf2);
    v = $urandom;
    for (int i = 0; i < 4; i++) begin
      wr(8'h10 + 8'(i), v[8*i +: 8]);
    end
    wr(8'h0e, 8'hff);
    wr(8'h0f, 8'hff);
    rd(8'h0e, 8'h00, 8'hf0);
    rd(8'h20, 8'h00, 8'hff);
    mem_move_active_i = 1'h1;
    wr(8'h11, ~v[15:8]);
    mem_move_active_i = 1'h0;
    for (int i = 0; i < 4; i++) begin
      rd(8'h10 + 8'(i), v[8*i +: 8], 8'hff);
    end
    script_base_data_i = ~v;
    pulse(script_base_wr_i);
    rd(8'h12, ~v[23:16], 8'hff);
    for (int i = 0; i < 8; i++) begin
      phase = 3'(i);
      pulse(req_go);
      @(negedge clk_sys_i);
      rd(8'h0e, 8'(i), 8'h07);
    end
    p = 2'($urandom);
    {parity_high_n_i, parity_low_n_i} = p;
    async_in_word_i = {16'($urandom), 1'h1};
    pulse(async_in_strobe_i);
    parity_high_n_i = ~p[1];
    rd(8'h0e, {4'h0, ~p[0], 3'h0}, 8'h08);
    rd(8'h0f, {4'h8, ~p[1], 3'h0}, 8'h88);
    async_in_word_i.wide = 1'h0;
    pulse(async_in_strobe_i);
    pulse(in_latch_take_i);
    rd(8'h0f, {4'h0, ~p[1], 3'h0}, 8'h88);
    sync_in_valid_i = 1'h1;
    for (int i = 0; i < 18; i++) begin
      sync_in_data_i = 16'($urandom);
      fq.push_back(sync_in_data_i);
      @(negedge clk_sys_i);
    end
    sync_in_data_i = ~sync_in_data_i;
    check("input ready", sync_in_ready_o, 1'h0);
    rd(8'h0e, 8'h00, 8'hf0);
    rd(8'h0f, 8'h10, 8'h10);
    sync_in_valid_i = 1'h0;
    repeat (80) begin
      stall = 1'($urandom);
      @(negedge clk_sys_i);
    end
    stall = 1'h1;
    rd(8'h0f, 8'h00, 8'h10);
    check("fifo drained", fifo_out_valid_o, 1'h0);
    sync_mode_i = 1'h1;
    load({16'($urandom), 1'h1});
    load({16'($urandom), 1'h1});
    rd(8'h0f, 8'h60, 8'he0);
    stall = 1'h0;
    repeat (6) @(negedge clk_sys_i);
    sync_mode_i = 1'h0;
    stall = 1'h1;
    load({16'($urandom), 1'h1});
    rd(8'h0f, 8'h20, 8'he0);
    stall = 1'h0;
    repeat (4) @(negedge clk_sys_i);
    check("words left", bq.size(), 0);
    pulse(selection_done_i);
    rd(8'h0f, 8'h02, 8'h02);
    pulse(block_move_exec_i);
    rd(8'h0f, 8'h00, 8'h02);
    pulse(bus_released_i);
    rd(8'h0f, 8'h02, 8'h02);
    pulse(select_response_i);
    pulse(block_move_exec_i);
    rd(8'h0f, 8'h00, 8'h02);
    complete_run();
  end
endmodule
